// File: hdl/ppo_port_regs.vh
// Operation
// [RQ1] Pull-up override enable makes the pull-up follow the override value alone.
// [RQ2] Without override, pull-up is on only for direction 0, output 1, disable 0.
// [RQ3] Under pull-up override, value 1 turns pull-up on, 0 turns it off.
// [RQ4] Direction override enable makes driver enable follow its value, else direction bit.
// [RQ5] Under direction override, value 1 enables the driver, 0 disables it.
// [RQ6] With driver on and value override enabled, the pad takes the override value.
// [RQ7] With value override off and driver on, the pad takes the output value bit.
// [RQ8] With value override enabled, the driven value equals the override value.
// [RQ9] Input enable override picks the input enable, else sleep state decides; the code also turns input on wherever pin change is enabled.
// [RQ10] Under input enable override, value 1 enables input, 0 disables it; the code keeps input on with value 0 while pin change is enabled.
// [RQ11] Peripherals get the raw input after the buffer, before the synchroniser.
// [RQ12] Each peripheral makes its own override enables and values.
// [RQ13] Strobes shared per port; clock, sleep, pull-up disable shared by all ports.
// [RQ14] Bit 7: main and timer oscillator output, pin change 7; bit 6 the inputs.
// [RQ15] Bits 5 to 2: SPI clock, MISO, MOSI, select; timer outputs on 3 and 2.
// [RQ16] Bit 1 timer1 match A; bit 0 capture in, divided clock, pin change 0.
// [RQ17] Bit 7 used as crystal clock pin is withheld from general I/O.
// [RQ18] Timer oscillator on bit 7 only with internal RC clock and async timer on.
// [RQ19] Async timer2 select 1 and external clock 0 detach bit 7 from the port.
// [RQ20] Bit 7 can raise pin change 7 whenever its pin change is enabled; the code holds bit 7 input off while it is a clock pin.
// [RQ21] While bit 7 is a clock pin, its direction, output and input read 0.
// [RQ22] Global pull-up disable set suppresses register-controlled pull-ups on all pins.
// [RQ23] Direction bit 1 makes an output, 0 an input, without override.
// [RQ24] Override selection is combinational, effective in the same cycle.
`ifndef PPO_PORT_REGS_VH
`define PPO_PORT_REGS_VH
`define PPO_IDX_PIN      4'h0
`define PPO_IDX_DIR      4'h1
`define PPO_IDX_OUT      4'h2
`define PPO_IDX_CTRL     4'h3
`define PPO_CTRL_PUD     0
`define PPO_CTRL_AS2     1
`define PPO_CTRL_EXTCLK  2
`define PPO_CTRL_INTRC   3
`define PPO_CTRL_XTAL    4
`define PPO_DIR_RST      8'h00
`define PPO_OUT_RST      8'h00
`define PPO_CTRL_RST     5'h08
`define PPO_SYNC_RST     8'h00
`endif

// File: hdl/ppo_port.v
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
`include "ppo_port_regs.vh"
module ppo_port #(
  parameter WIDTH = 8
) (
  input  wire             mclk_i,
  input  wire             sys_rst_i,
  input  wire             wb_cyc_i,
  input  wire             wb_stb_i,
  input  wire             wb_we_i,
  input  wire [5:2]       wb_adr_i,
  input  wire [3:0]       wb_sel_i,
  input  wire [31:0]      wb_dat_i,
  output wire [31:0]      wb_dat_o,
  output wire             wb_ack_o,
  input  wire             sleep_i,
  input  wire [WIDTH-1:0] pullup_override_en_i,
  input  wire [WIDTH-1:0] pullup_override_val_i,
  input  wire [WIDTH-1:0] dir_override_en_i,
  input  wire [WIDTH-1:0] dir_override_val_i,
  input  wire [WIDTH-1:0] value_override_en_i,
  input  wire [WIDTH-1:0] value_override_val_i,
  input  wire [WIDTH-1:0] input_en_override_en_i,
  input  wire [WIDTH-1:0] input_en_override_val_i,
  input  wire [WIDTH-1:0] pin_change_en_i,
  input  wire [WIDTH-1:0] pad_i,
  output wire [WIDTH-1:0] pad_o,
  output wire [WIDTH-1:0] pad_oe_o,
  output wire [WIDTH-1:0] pullup_en_o,
  output wire [WIDTH-1:0] input_en_o,
  output wire [WIDTH-1:0] alt_digital_input_o,
  output wire [WIDTH-1:0] pin_change_src_o,
  output wire             spi_sck_in_o,
  output wire             spi_miso_in_o,
  output wire             spi_mosi_in_o,
  output wire             spi_ss_in_o,
  output wire             timer1_capture_in_o,
  output wire             main_osc_pins_o,
  output wire             timer_osc_pins_o,
  output wire             global_pullup_disable_o
);

  // ***************************************************************
  // Registers
  // ***************************************************************
  reg  [WIDTH-1:0] direction_reg;
  reg  [WIDTH-1:0] direction_next;
  reg  [WIDTH-1:0] out_value_reg;
  reg  [WIDTH-1:0] out_value_next;
  reg  [4:0]       ctrl_reg;
  reg  [4:0]       ctrl_next;
  reg  [WIDTH-1:0] sync1_reg;
  reg  [WIDTH-1:0] sync2_reg;
  reg              ack_reg;
  reg  [31:0]      rdata_reg;
  reg  [31:0]      rdata_next;

  wire             bus_req;
  wire             wr_lane0;
  wire             global_pullup_disable;
  wire             async_timer2_select;
  wire             ext_clock_select;
  wire             int_rc_select;
  wire             xtal_select;
  wire             bit7_clock_pin;
  wire [WIDTH-1:0] clk_pin_mask;
  wire [WIDTH-1:0] pu_oe;
  wire [WIDTH-1:0] pu_ov;
  wire [WIDTH-1:0] dd_oe;
  wire [WIDTH-1:0] dd_ov;
  wire [WIDTH-1:0] ie_oe;
  wire [WIDTH-1:0] ie_ov;
  wire [WIDTH-1:0] drv_en;
  wire [WIDTH-1:0] in_en;
  wire [WIDTH-1:0] di_raw;

  // ***************************************************************
  // Pin selection helper
  // ***************************************************************
  function [WIDTH-1:0] ovr_sel;
    input [WIDTH-1:0] en;
    input [WIDTH-1:0] val;
    input [WIDTH-1:0] dflt;
    begin
      ovr_sel = (en & val) | (~en & dflt);
    end
  endfunction

  // ***************************************************************
  // Clock pin decode for bit 7
  // ***************************************************************
  assign global_pullup_disable = ctrl_reg[`PPO_CTRL_PUD];  // [RQ13]
  assign async_timer2_select   = ctrl_reg[`PPO_CTRL_AS2];
  assign ext_clock_select      = ctrl_reg[`PPO_CTRL_EXTCLK];
  assign int_rc_select         = ctrl_reg[`PPO_CTRL_INTRC];
  assign xtal_select           = ctrl_reg[`PPO_CTRL_XTAL];

  // Crystal clock pin when the crystal is selected and the RC oscillator is not the chip clock
  assign main_osc_pins_o  = xtal_select & ~int_rc_select;  // [RQ17]
  // Timer oscillator only with RC chip clock and async timer crystal
  assign timer_osc_pins_o = int_rc_select & async_timer2_select
                            & ~ext_clock_select;  // [RQ18] [RQ19]
  assign bit7_clock_pin   = main_osc_pins_o | timer_osc_pins_o;  // [RQ14]
  assign clk_pin_mask     = {bit7_clock_pin, {(WIDTH-1){1'b0}}};
  assign global_pullup_disable_o = global_pullup_disable;

  // ***************************************************************
  // Override merge, clock pin forces everything off
  // ***************************************************************
  assign pu_oe = pullup_override_en_i | clk_pin_mask;
  assign pu_ov = pullup_override_val_i & ~clk_pin_mask;
  assign dd_oe = dir_override_en_i | clk_pin_mask;
  assign dd_ov = dir_override_val_i & ~clk_pin_mask;
  assign ie_oe = input_en_override_en_i | clk_pin_mask | pin_change_en_i;  // [RQ20]
  assign ie_ov = (input_en_override_val_i | pin_change_en_i) & ~clk_pin_mask;

  // ***************************************************************
  // Pad control, combinational
  // ***************************************************************
  // Pull-up
  assign pullup_en_o = ovr_sel(pu_oe, pu_ov,
                       ~direction_reg & out_value_reg
                       & {WIDTH{~global_pullup_disable}});  // [RQ1] [RQ2] [RQ3] [RQ22] [RQ24]

  // Output driver enable
  assign drv_en   = ovr_sel(dd_oe, dd_ov, direction_reg);  // [RQ4] [RQ5] [RQ23] [RQ24]
  assign pad_oe_o = drv_en;

  // Driven value, only meaningful while driver enabled
  assign pad_o = ovr_sel(value_override_en_i, value_override_val_i,
                         out_value_reg) & drv_en;  // [RQ6] [RQ7] [RQ8] [RQ24]

  // Digital input enable, sleep clamps by default
  assign in_en      = ovr_sel(ie_oe, ie_ov, {WIDTH{~sleep_i}});  // [RQ9] [RQ10] [RQ24]
  assign input_en_o = in_en;

  // Raw input after clamp, before synchroniser
  assign di_raw              = pad_i & in_en;  // [RQ11]
  assign alt_digital_input_o = di_raw;  // [RQ11] [RQ12]

  // ***************************************************************
  // Alternate function inputs
  // ***************************************************************
  assign pin_change_src_o    = di_raw;  // [RQ14] [RQ15] [RQ16] [RQ20]
  assign spi_sck_in_o        = di_raw[5];  // [RQ15]
  assign spi_miso_in_o       = di_raw[4];  // [RQ15]
  assign spi_mosi_in_o       = di_raw[3];  // [RQ15]
  assign spi_ss_in_o         = di_raw[2];  // [RQ15]
  assign timer1_capture_in_o = di_raw[0];  // [RQ16]

  // ***************************************************************
  // Input synchroniser
  // ***************************************************************
  always @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sync1_reg <= `PPO_SYNC_RST;
      sync2_reg <= `PPO_SYNC_RST;
    end
    else
    begin
      sync1_reg <= di_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // ***************************************************************
  // Wishbone slave
  // ***************************************************************
  assign bus_req  = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];  // [RQ13]

  always @*
  begin
    direction_next = direction_reg;
    out_value_next = out_value_reg;
    ctrl_next      = ctrl_reg;
    rdata_next     = 32'h0000_0000;
    if (wr_lane0)
    begin
      case (wb_adr_i)
        `PPO_IDX_PIN:  out_value_next = out_value_reg ^ wb_dat_i[WIDTH-1:0];
        `PPO_IDX_DIR:  direction_next = wb_dat_i[WIDTH-1:0];
        `PPO_IDX_OUT:  out_value_next = wb_dat_i[WIDTH-1:0];
        `PPO_IDX_CTRL: ctrl_next      = wb_dat_i[4:0];
        default:       ctrl_next      = ctrl_reg;
      endcase
    end
    if (bus_req & ~wb_we_i)
    begin
      case (wb_adr_i)
        `PPO_IDX_PIN:  rdata_next[WIDTH-1:0] = sync2_reg & ~clk_pin_mask;  // [RQ21]
        `PPO_IDX_DIR:  rdata_next[WIDTH-1:0] = direction_reg & ~clk_pin_mask;  // [RQ21]
        `PPO_IDX_OUT:  rdata_next[WIDTH-1:0] = out_value_reg & ~clk_pin_mask;  // [RQ21]
        `PPO_IDX_CTRL: rdata_next[4:0]       = ctrl_reg;
        default:       rdata_next            = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      direction_reg <= `PPO_DIR_RST;
      out_value_reg <= `PPO_OUT_RST;
      ctrl_reg      <= `PPO_CTRL_RST;
      ack_reg       <= 1'b0;
      rdata_reg     <= 32'h0000_0000;
    end
    else
    begin
      direction_reg <= direction_next;
      out_value_reg <= out_value_next;
      ctrl_reg      <= ctrl_next;
      ack_reg       <= bus_req;
      rdata_reg     <= rdata_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

endmodule

// File: testbench/ppo_port_checker.sv
`timescale 1ns/100ps
// ****
// Checks
// ****
module ppo_port_checker (
  input wire logic       mclk_i,
  input wire logic       sys_rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       sleep_i,
  input wire logic       main_osc_pins_o,
  input wire logic       timer_osc_pins_o,
  input wire logic       global_pullup_disable_o,
  input wire logic [7:0] pullup_override_en_i,
  input wire logic [7:0] pullup_override_val_i,
  input wire logic [7:0] dir_override_en_i,
  input wire logic [7:0] dir_override_val_i,
  input wire logic [7:0] value_override_en_i,
  input wire logic [7:0] value_override_val_i,
  input wire logic [7:0] input_en_override_en_i,
  input wire logic [7:0] input_en_override_val_i,
  input wire logic [7:0] pin_change_en_i,
  input wire logic [7:0] pad_i,
  input wire logic [7:0] pad_o,
  input wire logic [7:0] pad_oe_o,
  input wire logic [7:0] pullup_en_o,
  input wire logic [7:0] input_en_o,
  input wire logic [7:0] alt_digital_input_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack pulse wrong");
  AST_PU_OVR: assert property (((pullup_en_o ^ pullup_override_val_i) & pullup_override_en_i & 8'h7f) == 0)
    else $error("pull-up override");
  AST_PU_GATE: assert property (global_pullup_disable_o |-> (pullup_en_o & ~pullup_override_en_i) == 0)
    else $error("pull-up not gated");
  AST_PU_DIR: assert property ((pullup_en_o & pad_oe_o & ~pullup_override_en_i & ~dir_override_en_i) == 0)
    else $error("pull-up on output");
  AST_DIR_OVR: assert property (((pad_oe_o ^ dir_override_val_i) & dir_override_en_i & 8'h7f) == 0)
    else $error("driver override");
  AST_VAL_OVR: assert property (((pad_o ^ value_override_val_i) & value_override_en_i & pad_oe_o) == 0)
    else $error("value override");
  AST_IE_OVR: assert property (((input_en_o ^ input_en_override_val_i) & input_en_override_en_i & 8'h7f) == 0)
    else $error("input override");
  AST_SLEEP: assert property (sleep_i |-> (input_en_o & ~input_en_override_en_i & ~pin_change_en_i) == 0)
    else $error("sleep clamp");
  AST_DI: assert property (alt_digital_input_o == (pad_i & input_en_o))
    else $error("alt input");
  AST_CLK7: assert property (main_osc_pins_o || timer_osc_pins_o |-> (pad_oe_o[7] | pullup_en_o[7]) == 0)
    else $error("clock pin used");
  cover property (|value_override_en_i && |pad_oe_o);
  cover property (timer_osc_pins_o);
  cover property (main_osc_pins_o);
endmodule
bind ppo_port ppo_port_checker u_chk (.*);

// File: testbench/ppo_periph_model.sv
`timescale 1ns/100ps
// ****
// Peripherals
// ****
module ppo_periph_model (
  input  wire logic       clk_i,
  input  wire logic       run_i,
  output reg        [7:0] pu_en_o, pu_val_o, dir_en_o, dir_val_o,
  output reg        [7:0] val_en_o, val_val_o, ie_en_o, ie_val_o, pc_en_o
);
  integer      seed = 32'h2558c93d;
  reg   [31:0] a, b, c;
  always @(posedge clk_i)
  begin
    a = run_i ? $random(seed) : 0;
    b = run_i ? $random(seed) : 0;
    c = run_i ? $random(seed) : 0;
    {pu_en_o, pu_val_o, dir_en_o, dir_val_o} <= a;
    {val_en_o, val_val_o, ie_en_o, ie_val_o} <= b;
    pc_en_o <= c[7:0] & ~b[15:8];
  end
endmodule

// File: testbench/testbench.sv
`timescale 1ns/100ps
`include "ppo_port_regs.vh"
// ****
// Bench
// ****
module testbench;
  logic        mclk_i = 0, sys_rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, sleep_i = 0, run = 0, chk = 0;
  logic [5:2]  wb_adr_i = 0;
  logic [3:0]  wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 0, q;
  logic [7:0]  pad_i = 0, dir, out, tg;
  logic [4:0]  ctl;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, spi_sck_in_o, spi_miso_in_o, spi_mosi_in_o, spi_ss_in_o, timer1_capture_in_o;
  wire         main_osc_pins_o, timer_osc_pins_o, global_pullup_disable_o;
  wire  [7:0]  pullup_override_en_i, pullup_override_val_i, dir_override_en_i, dir_override_val_i, pin_change_en_i;
  wire  [7:0]  value_override_en_i, value_override_val_i, input_en_override_en_i, input_en_override_val_i;
  wire  [7:0]  pad_o, pad_oe_o, pullup_en_o, input_en_o, alt_digital_input_o, pin_change_src_o;
  integer      errors = 0, checked = 0, seed = 32'h2558c93d, i, n;
  ppo_port uut (.*);
  ppo_periph_model u_per (.clk_i(mclk_i), .run_i(run), .pu_en_o(pullup_override_en_i),
    .pu_val_o(pullup_override_val_i), .dir_en_o(dir_override_en_i), .dir_val_o(dir_override_val_i),
    .val_en_o(value_override_en_i), .val_val_o(value_override_val_i), .ie_en_o(input_en_override_en_i),
    .ie_val_o(input_en_override_val_i), .pc_en_o(pin_change_en_i));
  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
    if (run)
      {pad_i, sleep_i} <= 9'($random(seed));
  function automatic [7:0] msk(input [4:0] c);
    msk = {~(c[4] & ~c[3] | c[3] & c[1] & ~c[2]), 7'h7f};
  endfunction
  task cmp(input string nm, input [31:0] e, input [31:0] g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wb(input w, input [3:0] a, input [7:0] d);
    @(posedge mclk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, 24'h0, d};
    @(posedge mclk_i);
    for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++)
      @(posedge mclk_i);
    if (n == 20)
    begin
      errors++;
      end_of_test;
    end
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task end_of_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(negedge mclk_i)
    if (chk)
    begin : refm
      logic [7:0] m, ie, oe, pu;
      m = msk(ctl);
      oe = (dir_override_en_i & dir_override_val_i | ~dir_override_en_i & dir) & m;
      ie = (input_en_override_en_i & input_en_override_val_i | ~input_en_override_en_i & (pin_change_en_i | {8{~sleep_i}})) & m;
      pu = (pullup_override_en_i & pullup_override_val_i | ~pullup_override_en_i & ~dir & out & {8{~ctl[0]}}) & m;
      cmp("pullup", pu, pullup_en_o);
      cmp("drv_en", oe, pad_oe_o);
      cmp("pad", (value_override_en_i & value_override_val_i | ~value_override_en_i & out) & oe, pad_o);
      cmp("in_en", ie, input_en_o);
      cmp("alt_in", pad_i & ie, alt_digital_input_o);
      cmp("pc_src", pad_i & ie, pin_change_src_o);
      cmp("periph_in", {pad_i[5:2] & ie[5:2], pad_i[0] & ie[0]}, {spi_sck_in_o,
        spi_miso_in_o, spi_mosi_in_o, spi_ss_in_o, timer1_capture_in_o});
      cmp("osc", {ctl[4] & ~ctl[3], ctl[3] & ctl[1] & ~ctl[2], ctl[0]}, {main_osc_pins_o,
        timer_osc_pins_o, global_pullup_disable_o});
    end
  initial
  begin
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 0;
    wb(0, `PPO_IDX_DIR, 0);
    cmp("dir_rst", `PPO_DIR_RST, q);
    wb(0, `PPO_IDX_CTRL, 0);
    cmp("ctl_rst", `PPO_CTRL_RST, q);
    wb(0, 4'h9, 0);
    cmp("unmapped", 0, q);
    for (i = 0; i < 16; i++)
    begin
      dir = $random(seed);
      out = $random(seed);
      tg = $random(seed);
      ctl = i == 0 ? 5'h10 : i == 1 ? 5'h0b : 5'($random(seed));
      wb(1, `PPO_IDX_DIR, dir);
      wb(1, `PPO_IDX_OUT, out);
      wb(1, `PPO_IDX_CTRL, ctl);
      wb(1, `PPO_IDX_PIN, tg);
      out = out ^ tg;
      wb(0, `PPO_IDX_DIR, 0);
      cmp("dir_rd", dir & msk(ctl), q);
      wb(0, `PPO_IDX_OUT, 0);
      cmp("out_rd", out & msk(ctl), q);
      wb(0, `PPO_IDX_CTRL, 0);
      cmp("ctl_rd", ctl, q);
      wb(0, `PPO_IDX_PIN, 0);
      cmp("pin7_rd", 0, q & ~msk(ctl));
      run <= 1;
      @(posedge mclk_i);
      chk = 1;
      repeat (30) @(posedge mclk_i);
      chk = 0;
      run <= 0;
      $display("test %0d done", i);
    end
    wb_sel_i <= 4'h0;
    wb(1, `PPO_IDX_DIR, ~dir);
    wb_sel_i <= 4'h1;
    wb(0, `PPO_IDX_DIR, 0);
    cmp("sel_off", dir & msk(ctl), q);
    wb(1, 4'h9, 8'hff);
    wb(0, `PPO_IDX_CTRL, 0);
    cmp("unmapped_wr", ctl, q);
    $display("test sel done");
    end_of_test;
  end
  initial
  begin
    #100000;
    errors++;
    end_of_test;
  end
endmodule
